/* hw/dual_loop_pid_controller.sv */
// Dual pressure/flow PID controller with low-select output
`timescale 1ns/100ps
module dual_loop_pid_controller
#(
   // Clocks per calculation cycle; the default is the 0.5 s figure, a bench may shorten it
   parameter int CYCLE_CLKS = pid_pkg::CYCLE_CLKS
)
(
   // Clock, reset, enable
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // Configuration
   input wire pid_pkg::press_cfg_t press_cfg_in,
   input wire logic bidir_in,
   input wire logic flow_negative_in,
   // Pressure measurements and setting
   input wire logic signed [pid_pkg::DATA_W-1:0] upstream_pressure_in,
   input wire logic signed [pid_pkg::DATA_W-1:0] downstream_pressure_in,
   input wire logic signed [pid_pkg::DATA_W-1:0] press_set_value_in,
   // Flow measurements and setting
   input wire logic signed [pid_pkg::DATA_W-1:0] flow_pos_value_in,
   input wire logic signed [pid_pkg::DATA_W-1:0] flow_neg_value_in,
   input wire logic signed [pid_pkg::DATA_W-1:0] flow_set_value_in,
   // Pressure loop tuning
   input wire logic signed [pid_pkg::COEF_W-1:0] press_kp_in,
   input wire logic signed [pid_pkg::COEF_W-1:0] press_ki_in,
   input wire logic signed [pid_pkg::COEF_W-1:0] press_kd_keep_in,
   input wire logic signed [pid_pkg::COEF_W-1:0] press_kd_gain_in,
   // Flow loop tuning
   input wire logic signed [pid_pkg::COEF_W-1:0] flow_kp_in,
   input wire logic signed [pid_pkg::COEF_W-1:0] flow_ki_in,
   input wire logic signed [pid_pkg::COEF_W-1:0] flow_kd_keep_in,
   input wire logic signed [pid_pkg::COEF_W-1:0] flow_kd_gain_in,
   // Results
   output logic signed [pid_pkg::DATA_W-1:0] valve_out,
   output logic press_wins_out,
   output logic cycle_tick_out
);
   logic [pid_pkg::TICK_W-1:0] tick_cnt_r;
   logic tick;
   logic flow_neg_r;
   logic signed [pid_pkg::DATA_W-1:0] press_pv_r;
   logic signed [pid_pkg::DATA_W-1:0] flow_pv_r;
   logic signed [pid_pkg::DATA_W-1:0] press_loop_out;
   logic signed [pid_pkg::DATA_W-1:0] flow_loop_out;
   logic step_r;
   pid_pkg::action_t press_action;

   assign tick = (tick_cnt_r == pid_pkg::TICK_ZERO);

   // Calculation cycle counter
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         tick_cnt_r <= pid_pkg::TICK_W'(CYCLE_CLKS - 1);
      end
      else if (ce_in)
      begin
         if (tick)
         begin
            tick_cnt_r <= pid_pkg::TICK_W'(CYCLE_CLKS - 1);
         end
         else
         begin
            tick_cnt_r <= tick_cnt_r - pid_pkg::TICK_ONE;
         end
      end
   end

   // Direction sampled at the tick, before measurements are picked
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         flow_neg_r <= 1'b0;
         step_r <= 1'b0;
      end
      else if (ce_in)
      begin
         step_r <= tick;
         if (tick)
         begin
            flow_neg_r <= bidir_in & flow_negative_in;
         end
      end
   end

   // Measurement selection, one cycle after the direction is caught
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         press_pv_r <= pid_pkg::OUT_ZERO;
         flow_pv_r <= pid_pkg::OUT_ZERO;
      end
      else if (ce_in)
      begin
         flow_pv_r <= flow_neg_r ? flow_neg_value_in : flow_pos_value_in;
         if (press_cfg_in == pid_pkg::PRESS_OUTLET)
         begin
            press_pv_r <= flow_neg_r ? upstream_pressure_in
                                     : downstream_pressure_in;
         end
         else
         begin
            press_pv_r <= flow_neg_r ? downstream_pressure_in
                                     : upstream_pressure_in;
         end
      end
   end

   // Pressure loop action follows the configuration
   assign press_action = (press_cfg_in == pid_pkg::PRESS_INLET) ?
      pid_pkg::ACT_FORWARD : pid_pkg::ACT_REVERSE;

   // Pressure loop
   pid_loop u_press_loop
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .step_in(step_r),
      .action_in(press_action),
      .process_value_in(press_pv_r),
      .set_value_in(press_set_value_in),
      .kp_in(press_kp_in),
      .ki_in(press_ki_in),
      .kd_keep_in(press_kd_keep_in),
      .kd_gain_in(press_kd_gain_in),
      .loop_out(press_loop_out)
   );

   // Flow loop, always reverse
   pid_loop u_flow_loop
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .step_in(step_r),
      .action_in(pid_pkg::ACT_REVERSE),
      .process_value_in(flow_pv_r),
      .set_value_in(flow_set_value_in),
      .kp_in(flow_kp_in),
      .ki_in(flow_ki_in),
      .kd_keep_in(flow_kd_keep_in),
      .kd_gain_in(flow_kd_gain_in),
      .loop_out(flow_loop_out)
   );

   // Low select onto the valve channel
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         valve_out <= pid_pkg::OUT_ZERO;
         press_wins_out <= 1'b0;
         cycle_tick_out <= 1'b0;
      end
      else if (ce_in)
      begin
         cycle_tick_out <= step_r;
         press_wins_out <= (press_loop_out < flow_loop_out);
         valve_out <= (press_loop_out < flow_loop_out) ? press_loop_out
                                                        : flow_loop_out;
      end
   end

   // Output never exceeds either loop output
   a_low_select: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ce_in |=> (valve_out <= $past(press_loop_out)) && (valve_out <= $past(flow_loop_out)))
      else $error("valve output above a loop output");
   // A tick is never followed by another tick on the next clock
   a_tick_single: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (ce_in && tick) |=> !tick)
      else $error("calculation tick repeated");
   // Outlet mode, positive flow picks downstream pressure
   a_outlet_pos: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (ce_in && !flow_neg_r && press_cfg_in == pid_pkg::PRESS_OUTLET)
      |=> press_pv_r == $past(downstream_pressure_in))
      else $error("wrong outlet pressure sensor");
   // Inlet mode, positive flow picks upstream pressure
   a_inlet_pos: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (ce_in && !flow_neg_r && press_cfg_in == pid_pkg::PRESS_INLET)
      |=> press_pv_r == $past(upstream_pressure_in))
      else $error("wrong inlet pressure sensor");
   // Negative flow picks the negative flow stream
   a_flow_stream: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (ce_in && flow_neg_r) |=> flow_pv_r == $past(flow_neg_value_in))
      else $error("wrong flow stream");
   // Direction ignored in unidirectional mode
   a_dir_sample: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (ce_in && tick && !bidir_in) |=> !flow_neg_r)
      else $error("direction used outside bidirectional mode");
   // Outputs capped at full scale
   a_full_scale: assert property (@(posedge core_clk_in) disable iff (rst_in)
      valve_out <= pid_pkg::OUT_FULL)
      else $error("valve above full scale");
   // Reset clears the output
   a_reset_clear: assert property (@(posedge core_clk_in)
      rst_in |=> valve_out == pid_pkg::OUT_ZERO)
      else $error("reset did not clear output");
endmodule // dual_loop_pid_controller

/* include/pid_pkg.sv */
// Constants and types shared by the dual-loop controller
package pid_pkg;
   // Data widths: values are signed fixed point, Q16.16 is avoided; 16-bit integer units of 0.01 %
   localparam int DATA_W = 16;
   localparam int COEF_W = 16;
   localparam int FRAC_W = 12; // Fraction bits of every coefficient
   localparam int ACC_W = 40;
   // Full-scale output, 100 % coded as this count
   localparam logic signed [DATA_W-1:0] OUT_FULL = 16'sh2710;
   localparam logic signed [DATA_W-1:0] OUT_ZERO = 16'sh0000;
   localparam logic signed [ACC_W-1:0] ACC_ZERO = 40'sh00_0000_0000;
   // Calculation cycle, 0.5 s at 100 MHz
   localparam int CLK_PERIOD_NS = 10;
   localparam int CYCLE_TIME_MS = 500;
   localparam int CYCLE_CLKS = (CYCLE_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int TICK_W = 26;
   localparam logic [TICK_W-1:0] TICK_ONE = 26'h000_0001;
   localparam logic [TICK_W-1:0] TICK_ZERO = 26'h000_0000;
   // Derivative filter constant
   localparam int FILTER_N = 10;
   // Loop configuration
   typedef enum logic {PRESS_OUTLET, PRESS_INLET} press_cfg_t;
   typedef enum logic {ACT_FORWARD, ACT_REVERSE} action_t;
endpackage

/* hw/pid_loop.sv */
// One discrete PID loop with filtered derivative term
`timescale 1ns/100ps
module pid_loop
(
   // Clock and control
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic step_in,
   input wire pid_pkg::action_t action_in,
   // Measurements
   input wire logic signed [pid_pkg::DATA_W-1:0] process_value_in,
   input wire logic signed [pid_pkg::DATA_W-1:0] set_value_in,
   // Tuning: gain, T*Kp/Ti, Td/(Td+NT), Td*N/(Td+NT)*Kp in fraction units
   input wire logic signed [pid_pkg::COEF_W-1:0] kp_in,
   input wire logic signed [pid_pkg::COEF_W-1:0] ki_in,
   input wire logic signed [pid_pkg::COEF_W-1:0] kd_keep_in,
   input wire logic signed [pid_pkg::COEF_W-1:0] kd_gain_in,
   // Result
   output logic signed [pid_pkg::DATA_W-1:0] loop_out
);
   logic signed [pid_pkg::ACC_W-1:0] integ_r;
   logic signed [pid_pkg::ACC_W-1:0] integ_nxt;
   logic signed [pid_pkg::ACC_W-1:0] deriv_r;
   logic signed [pid_pkg::ACC_W-1:0] deriv_nxt;
   logic signed [pid_pkg::DATA_W:0] err_prev_r;
   logic signed [pid_pkg::DATA_W:0] err;
   logic signed [pid_pkg::ACC_W-1:0] prop;
   logic signed [pid_pkg::ACC_W-1:0] sum;
   logic signed [pid_pkg::ACC_W-1:0] full_acc;

   // Error is measurement minus setting, sign flipped for reverse action
   always_comb
   begin
      err = 17'(process_value_in) - 17'(set_value_in);
      if (action_in == pid_pkg::ACT_REVERSE)
      begin
         err = -err;
      end
   end

   assign full_acc = 40'(pid_pkg::OUT_FULL) <<< pid_pkg::FRAC_W;
   assign prop = 40'(kp_in) * 40'(err);
   assign deriv_nxt = ((40'(kd_keep_in) * deriv_r) >>> pid_pkg::FRAC_W)
      + 40'(kd_gain_in) * (40'(err) - 40'(err_prev_r));

   // Integral grows until the loop output reaches full scale
   always_comb
   begin
      integ_nxt = integ_r + 40'(ki_in) * 40'(err);
      if (prop + integ_nxt + deriv_nxt > full_acc)
      begin
         integ_nxt = full_acc - prop - deriv_nxt;
      end
   end

   assign sum = prop + integ_r + deriv_r;

   // PID state, updated once per calculation cycle
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         integ_r <= pid_pkg::ACC_ZERO;
         deriv_r <= pid_pkg::ACC_ZERO;
         err_prev_r <= '0;
      end
      else if (ce_in && step_in)
      begin
         integ_r <= integ_nxt;
         deriv_r <= deriv_nxt;
         err_prev_r <= err;
      end
   end

   // Loop output register, saturated to the output range
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         loop_out <= pid_pkg::OUT_ZERO;
      end
      else if (ce_in)
      begin
         if (sum >= full_acc)
         begin
            loop_out <= pid_pkg::OUT_FULL;
         end
         else if (sum < pid_pkg::ACC_ZERO)
         begin
            loop_out <= pid_pkg::OUT_ZERO;
         end
         else
         begin
            loop_out <= 16'(sum >>> pid_pkg::FRAC_W);
         end
      end
   end
endmodule // pid_loop

/* test/valve_model.sv */
// Behavioural final control valve fed from the analogue output channel
`timescale 1ns/100ps
module valve_model
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Command from the controller
   input wire logic signed [pid_pkg::DATA_W-1:0] valve_cmd_in,
   // Stem position and fault flag
   output logic signed [pid_pkg::DATA_W-1:0] position_out,
   output logic range_fault_out
);
   // Stem creeps one count per clock toward the command, like a slow actuator
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         position_out <= pid_pkg::OUT_ZERO;
         range_fault_out <= 1'b0;
      end
      else
      begin
         if (position_out < valve_cmd_in)
            position_out <= position_out + 16'sh0001;
         else if (position_out > valve_cmd_in)
            position_out <= position_out - 16'sh0001;
         // A command outside 0..full scale cannot be set on the channel
         if (valve_cmd_in < pid_pkg::OUT_ZERO || valve_cmd_in > pid_pkg::OUT_FULL)
            range_fault_out <= 1'b1;
      end
   end
endmodule // valve_model

/* test/test_dual_loop_pid_controller.sv */
// Self-checking bench for the dual-loop controller
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %0t got %0d expected %0d", $time, g, e); end end
module test_dual_loop_pid_controller;
   typedef logic signed [pid_pkg::DATA_W-1:0] val_t;
   typedef struct {pid_pkg::press_cfg_t cfg; logic bd; logic ng; val_t up; val_t dn; val_t ps;
      val_t fp; val_t fn; val_t fs; val_t v; logic w;} row_t;
   // Shortened calculation cycle so that every row fits the run budget
   localparam int CYC = 200;
   localparam int LIMIT = CYC + 10;
   logic core_clk_in, rst_in, ce_in, bidir_in, flow_negative_in, fault;
   pid_pkg::press_cfg_t press_cfg_in;
   val_t up, dn, ps, fp, fn, fs, kp, ki, kdk, kdg, valve_out, pos;
   logic press_wins_out, cycle_tick_out;
   int fail_count, samples_checked, n;
   row_t rows [8];
   // Unit gain, no integral or derivative: each loop output equals its acting error limited to 0..full scale
   initial
   begin
      rows[0] = '{pid_pkg::PRESS_INLET, 0, 1, 300, 0, 200, 0, 900, 200, 100, 1};
      rows[1] = '{pid_pkg::PRESS_OUTLET, 0, 0, 0, 100, 200, 0, 0, 500, 100, 1};
      rows[2] = '{pid_pkg::PRESS_OUTLET, 1, 1, 150, 500, 200, 900, 0, 200, 50, 1};
      rows[3] = '{pid_pkg::PRESS_INLET, 1, 1, 0, 260, 200, 900, 0, 200, 60, 1};
      rows[4] = '{pid_pkg::PRESS_INLET, 1, 0, 270, 0, 200, 0, 900, 200, 70, 1};
      rows[5] = '{pid_pkg::PRESS_OUTLET, 1, 0, 500, 120, 200, 0, 900, 200, 80, 1};
      rows[6] = '{pid_pkg::PRESS_INLET, 0, 0, 100, 0, 200, 0, 0, 200, 0, 1};
      rows[7] = '{pid_pkg::PRESS_INLET, 0, 0, 1200, 0, 200, 100, 0, 400, 300, 0};
   end
   // Free-running clock
   initial
   begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   dual_loop_pid_controller #(.CYCLE_CLKS(CYC)) u_dut (.core_clk_in(core_clk_in),
      .rst_in(rst_in), .ce_in(ce_in),
      .press_cfg_in(press_cfg_in), .bidir_in(bidir_in), .flow_negative_in(flow_negative_in),
      .upstream_pressure_in(up), .downstream_pressure_in(dn), .press_set_value_in(ps),
      .flow_pos_value_in(fp), .flow_neg_value_in(fn), .flow_set_value_in(fs),
      .press_kp_in(kp), .press_ki_in(ki), .press_kd_keep_in(kdk), .press_kd_gain_in(kdg),
      .flow_kp_in(kp), .flow_ki_in(ki), .flow_kd_keep_in(kdk), .flow_kd_gain_in(kdg),
      .valve_out(valve_out), .press_wins_out(press_wins_out), .cycle_tick_out(cycle_tick_out));
   valve_model u_valve (.core_clk_in(core_clk_in), .rst_in(rst_in), .valve_cmd_in(valve_out),
      .position_out(pos), .range_fault_out(fault));
   // Prints counts and verdict, then stops
   task automatic conclude();
      $display("checked %0d failed %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Waits for the update pulse under a bound, then steps past it
   task automatic wait_tick();
      n = 0;
      while (cycle_tick_out !== 1'b1 && n < LIMIT)
      begin
         @(negedge core_clk_in);
         n++;
      end
      if (n >= LIMIT)
      begin
         fail_count++;
         $display("[ERR] %0t update pulse missing", $time);
         conclude();
      end
      @(negedge core_clk_in);
   endtask
   // Main sequence
   initial
   begin
      {rst_in, ce_in} = 2'b11;
      {bidir_in, flow_negative_in} = 2'b00;
      press_cfg_in = pid_pkg::PRESS_INLET;
      {up, dn, ps, fp, fn, fs} = {6{16'sh0000}};
      kp = 16'sh1000;
      ki = 16'sh0000;
      kdk = 16'sh0800;
      kdg = 16'sh0000;
      fail_count = 0;
      samples_checked = 0;
      repeat (6) @(negedge core_clk_in);
      rst_in = 1'b0;
      `CHK(valve_out, pid_pkg::OUT_ZERO)
      `CHK(press_wins_out, 1'b0)
      // No update may come before a full calculation cycle
      repeat (CYC)
      begin
         @(negedge core_clk_in);
         `CHK(cycle_tick_out, 1'b0)
      end
      // First update pulse lands right after a full cycle
      @(negedge core_clk_in);
      `CHK(cycle_tick_out, 1'b1)
      $display("test reset done");
         foreach (rows[i])
         begin
            {press_cfg_in, bidir_in, flow_negative_in} = {rows[i].cfg, rows[i].bd, rows[i].ng};
            {up, dn, ps, fp, fn, fs} = {rows[i].up, rows[i].dn, rows[i].ps,
               rows[i].fp, rows[i].fn, rows[i].fs};
            wait_tick();
            wait_tick();
            @(negedge core_clk_in);
            `CHK(valve_out, rows[i].v)
            `CHK(press_wins_out, rows[i].w)
            $display("test row %0d done", i);
         end
         // A reset in mid-run clears every loop
         rst_in = 1'b1;
         @(negedge core_clk_in);
         rst_in = 1'b0;
         `CHK(valve_out, pid_pkg::OUT_ZERO)
         $display("test midrun reset done");
         // Proportional path recovers, then a low enable freezes the output
         repeat (5) @(negedge core_clk_in);
         `CHK(valve_out, 16'sh012c)
         ce_in = 1'b0;
         up = 16'sh012c;
         repeat (5) @(negedge core_clk_in);
         `CHK(valve_out, 16'sh012c)
         ce_in = 1'b1;
         repeat (5) @(negedge core_clk_in);
         `CHK(valve_out, 16'sh0064)
         $display("test clock enable done");
      `CHK(fault, 1'b0)
      conclude();
   end
endmodule // test_dual_loop_pid_controller
